//--- design/adcc_regs.sv
// What this block does
// - Busy flag is read-only: 1 while converting, 0 otherwise.
// - Finishing the low-high-low start sequence sets busy to 1.
// - Busy clears to 0 when the running conversion finishes.
// - Enable bit powers the converter on at 1, off at 0.
// - Result registers stay unchanged while the converter is disabled.
// - Format 0: high D[11:4], low D[3:0]; format 1: high D[11:8], low D[7:0].
// - The 12-bit result is split over both result registers by format.
// - Bits 3 to 0 of control register zero always read zero.
// - While start is held high the converter core is held in reset.
`timescale 1ns/100ps
`include "adcc_map.svh"

module adcc_regs
  import adcc_pkg::*;
(
  input wire logic mclk_i, // System clock, 20 MHz.
  input wire logic reset_n_i, // Synchronous reset, active low.
  input wire logic [4:0] avs_address_i, // Avalon byte address.
  input wire logic avs_read_i, // Avalon read request.
  input wire logic avs_write_i, // Avalon write request.
  input wire logic [31:0] avs_writedata_i, // Avalon write data.
  input wire logic [3:0] avs_byteenable_i, // Avalon byte enables.
  output logic [31:0] avs_readdata_o, // Avalon read data, registered.
  output logic avs_waitrequest_o, // Avalon wait request.
  output adcc_core_ctrl_t core_ctrl_o, // Reset, enable and start to the core.
  input wire adcc_core_stat_t core_stat_i, // Done pulse and data from the core.
  output logic irq_o // Level interrupt.
);

  ////////////////////////////////////////////////////////////////////////////
  // State and helpers.

  adcc_regs_t st;
  adcc_regs_t next_st;

  logic req;
  logic access;
  logic wr_lane0;
  logic busy;
  logic [7:0] res_high;
  logic [7:0] res_low;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [1:0] irq_set;
  logic irq_clr_wr;
  logic irq_mask_wr;

  function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
    hit = (addr == ofs);
  endfunction

  function automatic logic [31:0] zext8(input logic [7:0] v);
    zext8 = {24'h00_0000, v};
  endfunction

  assign busy = (st.state == ADCC_CONV);

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave handshake.

  // One wait state on every access lets the read data come from a flip-flop.
  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~st.ack;
  assign access = req & st.ack;
  assign wr_lane0 = access & avs_write_i & avs_byteenable_i[0];

  ////////////////////////////////////////////////////////////////////////////
  // Result placement and interrupts.

  adcc_fmt u_fmt (
    .raw_i(st.result),
    .format_i(st.format),
    .high_o(res_high),
    .low_o(res_low)
  );

  assign irq_clr_wr = wr_lane0 & hit(avs_address_i, `ADCC_OFS_IRQ_STAT);
  assign irq_mask_wr = wr_lane0 & hit(avs_address_i, `ADCC_OFS_IRQ_MASK);

  adcc_irq u_irq (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .set_i(irq_set),
    .clr_wr_i(irq_clr_wr),
    .mask_wr_i(irq_mask_wr),
    .wdata_i(avs_writedata_i[1:0]),
    .status_o(irq_status),
    .mask_o(irq_mask),
    .irq_o(irq_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    next_st = st;
    irq_set = `ADCC_IRQ_RST;
    next_st.start_pulse = 1'b0;
    next_st.ack = req & ~st.ack;

    // Register writes. The busy position has no storage, so writes to it vanish.
    if (wr_lane0 && hit(avs_address_i, `ADCC_OFS_CTRL0)) begin
      next_st.start = avs_writedata_i[`ADCC_BIT_START];
      next_st.enable = avs_writedata_i[`ADCC_BIT_ENABLE];
      next_st.format = avs_writedata_i[`ADCC_BIT_FORMAT];
    end
    if (wr_lane0 && hit(avs_address_i, `ADCC_OFS_CTRL1)) begin
      next_st.ctrl1 = avs_writedata_i[7:0];
    end

    // Conversion sequencing, driven by the stored start bit.
    case (st.state)
      ADCC_IDLE: begin
        if (st.start) begin
          next_st.state = ADCC_ARMED;
        end
      end
      ADCC_ARMED: begin
        // Start has gone high; its fall completes the sequence.
        if (!st.start) begin
          next_st.state = ADCC_CONV;
          next_st.start_pulse = 1'b1;
        end
      end
      ADCC_CONV: begin
        if (!st.enable) begin
          // A powered-down core never finishes, so give up instead of hanging.
          next_st.state = ADCC_IDLE;
          irq_set[`ADCC_IRQ_ABORT] = 1'b1;
        end else if (st.start) begin
          // Raising start again resets the core and restarts the sequence.
          next_st.state = ADCC_ARMED;
          irq_set[`ADCC_IRQ_ABORT] = 1'b1;
        end else if (core_stat_i.done) begin
          next_st.state = ADCC_IDLE;
          next_st.result = core_stat_i.data;
          irq_set[`ADCC_IRQ_DONE] = 1'b1;
        end
      end
      default: begin
        next_st.state = ADCC_IDLE;
      end
    endcase

    // Read data is captured in the wait cycle and held for the answer edge.
    if (req && !st.ack) begin
      next_st.rdata = `ADCC_READ_ZERO;
      if (avs_read_i) begin
        case (avs_address_i)
          `ADCC_OFS_CTRL0: begin
            next_st.rdata = zext8({st.start, busy, st.enable, st.format,
                                   `ADCC_LOW_NIBBLE_ZERO});
          end
          `ADCC_OFS_CTRL1: begin
            next_st.rdata = zext8(st.ctrl1);
          end
          `ADCC_OFS_RES_HIGH: begin
            next_st.rdata = zext8(res_high);
          end
          `ADCC_OFS_RES_LOW: begin
            next_st.rdata = zext8(res_low);
          end
          `ADCC_OFS_IRQ_STAT: begin
            next_st.rdata = {30'h0000_0000, irq_status};
          end
          `ADCC_OFS_IRQ_MASK: begin
            next_st.rdata = {30'h0000_0000, irq_mask};
          end
          default: begin
            next_st.rdata = `ADCC_READ_ZERO;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      st <= '{state: ADCC_IDLE, start: 1'b0, enable: 1'b0, format: 1'b0,
              ctrl1: `ADCC_CTRL1_RST, result: `ADCC_RESULT_RST,
              start_pulse: 1'b0, ack: 1'b0, rdata: `ADCC_READ_ZERO};
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign avs_readdata_o = st.rdata;
  assign core_ctrl_o.reset = st.start;
  assign core_ctrl_o.enable = st.enable;
  assign core_ctrl_o.start = st.start_pulse;

endmodule

//--- design/adcc_map.svh
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH

// Byte addresses of the registers on the Avalon-MM slave.
`define ADCC_OFS_CTRL0 5'h00
`define ADCC_OFS_CTRL1 5'h04
`define ADCC_OFS_RES_HIGH 5'h08
`define ADCC_OFS_RES_LOW 5'h0c
`define ADCC_OFS_IRQ_STAT 5'h10
`define ADCC_OFS_IRQ_MASK 5'h14

// Field positions inside adc_control_zero.
`define ADCC_BIT_START 7
`define ADCC_BIT_BUSY 6
`define ADCC_BIT_ENABLE 5
`define ADCC_BIT_FORMAT 4

// Reset values.
`define ADCC_CTRL1_RST 8'h00
`define ADCC_RESULT_RST 12'h000
`define ADCC_IRQ_RST 2'h0
`define ADCC_LOW_NIBBLE_ZERO 4'h0
`define ADCC_READ_ZERO 32'h0000_0000

// Interrupt status and mask bits.
`define ADCC_IRQ_DONE 0
`define ADCC_IRQ_ABORT 1

`endif

//--- design/adcc_pkg.sv
package adcc_pkg;

  // Gray coded along idle, armed, converting.
  typedef enum logic [1:0] {
    ADCC_IDLE = 2'b00,
    ADCC_ARMED = 2'b01,
    ADCC_CONV = 2'b11
  } adcc_state_t;

  typedef struct packed {
    logic reset;
    logic enable;
    logic start;
  } adcc_core_ctrl_t;

  typedef struct packed {
    logic done;
    logic [11:0] data;
  } adcc_core_stat_t;

  typedef struct packed {
    logic [1:0] status;
    logic [1:0] mask;
  } adcc_irq_state_t;

  typedef struct packed {
    adcc_state_t state;
    logic start;
    logic enable;
    logic format;
    logic [7:0] ctrl1;
    logic [11:0] result;
    logic start_pulse;
    logic ack;
    logic [31:0] rdata;
  } adcc_regs_t;

endpackage

//--- design/adcc_irq.sv
`timescale 1ns/100ps
`include "adcc_map.svh"

module adcc_irq
  import adcc_pkg::*;
(
  input wire logic mclk_i, // System clock.
  input wire logic reset_n_i, // Synchronous reset, active low.
  input wire logic [1:0] set_i, // Event pulses.
  input wire logic clr_wr_i, // Write to status register.
  input wire logic mask_wr_i, // Write to mask register.
  input wire logic [1:0] wdata_i, // Write data for either register.
  output logic [1:0] status_o, // Sticky status bits.
  output logic [1:0] mask_o, // Mask bits.
  output logic irq_o // Level interrupt.
);

  adcc_irq_state_t st;
  adcc_irq_state_t next_st;

  // An event in the same cycle as its clear survives, so no event is lost.
  always_comb begin
    next_st = st;
    if (clr_wr_i) begin
      next_st.status = st.status & ~wdata_i;
    end
    next_st.status = next_st.status | set_i;
    if (mask_wr_i) begin
      next_st.mask = wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      st <= '{status: `ADCC_IRQ_RST, mask: `ADCC_IRQ_RST};
    end else begin
      st <= next_st;
    end
  end

  assign status_o = st.status;
  assign mask_o = st.mask;
  assign irq_o = |(st.status & st.mask);

endmodule

//--- design/adcc_fmt.sv
`timescale 1ns/100ps
`include "adcc_map.svh"

module adcc_fmt
  import adcc_pkg::*;
(
  input wire logic [11:0] raw_i, // Stored conversion result.
  input wire logic format_i, // Result placement select.
  output logic [7:0] high_o, // High result byte.
  output logic [7:0] low_o // Low result byte.
);

  function automatic logic [15:0] place(input logic [11:0] d, input logic fmt);
    if (fmt) begin
      place = {`ADCC_LOW_NIBBLE_ZERO, d};
    end else begin
      place = {d, `ADCC_LOW_NIBBLE_ZERO};
    end
  endfunction

  // Format 0 gives D[11:4] high and D[3:0] in the upper nibble of low.
  assign high_o = place(raw_i, format_i)[15:8];
  assign low_o = place(raw_i, format_i)[7:0];

endmodule

//--- bench/adcc_core_model.sv
`timescale 1ns/100ps
module adcc_core_model
  import adcc_pkg::*;
#(parameter int CONV_CYCLES = 20)
(
  input wire logic mclk_i, // System clock.
  input wire adcc_core_ctrl_t ctrl_i, // Controls from the block.
  input wire logic [11:0] sample_i, // Value to convert.
  output adcc_core_stat_t stat_o // Done and data.
);
  int cnt = 0;
  initial stat_o = '0;
  // Data is inverted outside the done pulse so that a late capture shows up.
  always @(posedge mclk_i) begin
    stat_o.done <= 1'b0;
    stat_o.data <= ~sample_i;
    if (ctrl_i.reset || !ctrl_i.enable) cnt <= 0;
    else if (ctrl_i.start) cnt <= CONV_CYCLES;
    else if (cnt == 1) begin
      cnt <= 0;
      stat_o <= {1'b1, sample_i};
    end
    else if (cnt > 0) cnt <= cnt - 1;
  end
endmodule

//--- bench/adcc_regs_props.sv
`timescale 1ns/100ps
module adcc_regs_props
  import adcc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire adcc_core_ctrl_t core_ctrl_o,
  input wire adcc_core_stat_t core_stat_i,
  input wire logic irq_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  logic rd_done;
  logic wr0;
  assign rd_done = avs_read_i && !avs_waitrequest_o;
  assign wr0 = avs_write_i && !avs_waitrequest_o && avs_address_i == 5'h00 && avs_byteenable_i[0];
  wait_state_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("wait state not one cycle");
  reset_vals_a: assert property (disable iff (1'b0) !reset_n_i |=> avs_readdata_o == '0 && core_ctrl_o == '0 && !irq_o)
    else $error("outputs not cleared by reset");
  upper_zero_a: assert property (rd_done |-> avs_readdata_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  ctrl_low_a: assert property (rd_done && avs_address_i == 5'h00 |-> avs_readdata_o[3:0] == 4'h0)
    else $error("control low nibble not zero");
  enable_follow_a: assert property (wr0 |=> core_ctrl_o.enable == $past(avs_writedata_i[5]))
    else $error("enable does not follow write");
  reset_follow_a: assert property (wr0 |=> core_ctrl_o.reset == $past(avs_writedata_i[7]))
    else $error("core reset does not follow start bit");
  start_cause_a: assert property (core_ctrl_o.start |-> !core_ctrl_o.reset &&
    ($past(core_ctrl_o.reset) || $past(core_ctrl_o.reset, 2)))
    else $error("start pulse without start fall");
  start_pulse_a: assert property (core_ctrl_o.start |=> !core_ctrl_o.start)
    else $error("start pulse too long");
endmodule

//--- bench/adcc_regs_tb.sv
`timescale 1ns/100ps
module adcc_regs_tb;
  import adcc_pkg::*;
  logic mclk_i, reset_n_i, avs_read_i, avs_write_i, avs_waitrequest_o, irq_o;
  logic [4:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, q, seed;
  logic [3:0] avs_byteenable_i;
  logic [11:0] sample_i;
  logic [15:0] e;
  logic f;
  adcc_core_ctrl_t core_ctrl_o;
  adcc_core_stat_t core_stat_i;
  int fail_count = 0;
  int num_checks = 0;
  int n;
  adcc_regs adcc_regs_i (.*);
  adcc_core_model adcc_core_model_i (.mclk_i(mclk_i), .ctrl_i(core_ctrl_o), .sample_i(sample_i), .stat_o(core_stat_i));
  always #25 mclk_i = ~mclk_i;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] fmt_exp(input logic [11:0] d, input logic fs);
    return fs ? {4'h0, d} : {d, 4'h0};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // A spare edge after release keeps back-to-back calls from driving twice in one step.
  task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d, output logic [31:0] r);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= {24'h0, d};
    // Waitrequest is looked at mid-cycle, where it has settled, and the next rising edge is the answer edge.
    @(negedge mclk_i);
    for (n = 0; n < 50 && avs_waitrequest_o !== 1'b0; n++) @(negedge mclk_i);
    if (n == 50) fail_count++;
    @(posedge mclk_i);
    r = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge mclk_i);
    fail_count++;
    stop_test();
  end
  initial begin
    {mclk_i, reset_n_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i, sample_i} = '0;
    avs_byteenable_i = 4'hf;
    seed = 32'h8e49;
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    bus(5'h00, 0, 0, q); chk(q, 0);
    bus(5'h04, 0, 0, q); chk(q, 0);
    bus(5'h14, 1, 8'h01, q);
    bus(5'h00, 1, 8'h4f, q); bus(5'h00, 0, 0, q); chk(q, 0);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(lfsr(seed));
      f = seed[4];
      sample_i <= seed[27:16];
      bus(5'h04, 1, seed[7:0], q); bus(5'h04, 0, 0, q); chk(q, {24'h0, seed[7:0]});
      bus(5'h00, 1, {3'b101, f, 4'h0}, q);
      bus(5'h00, 1, {3'b001, f, 4'h0}, q);
      bus(5'h00, 0, 0, q); chk(q, {24'h0, 3'b011, f, 4'h0});
      for (n = 0; n < 100 && irq_o !== 1'b1; n++) @(posedge mclk_i);
      bus(5'h00, 0, 0, q); chk(q, {24'h0, 3'b001, f, 4'h0});
      e = fmt_exp(seed[27:16], f);
      bus(5'h08, 0, 0, q); chk(q, {24'h0, e[15:8]});
      bus(5'h00, 1, {3'b001, !f, 4'h0}, q);
      e = fmt_exp(seed[27:16], !f);
      bus(5'h0c, 0, 0, q); chk(q, {24'h0, e[7:0]});
      bus(5'h10, 1, 8'h01, q); chk({31'h0, irq_o}, 0);
    end
    bus(5'h00, 1, {3'b000, !f, 4'h0}, q);
    sample_i <= ~sample_i;
    bus(5'h00, 1, 8'h80, q);
    bus(5'h00, 1, 8'h00, q);
    repeat (30) @(posedge mclk_i);
    bus(5'h0c, 0, 0, q); chk(q, {24'h0, e[7:0]});
    chk({31'h0, irq_o}, 0);
    avs_byteenable_i <= 4'h0;
    bus(5'h00, 1, 8'h20, q);
    avs_byteenable_i <= 4'hf;
    bus(5'h00, 0, 0, q); chk(q, {24'h0, 3'b000, !f, 4'h0});
    bus(5'h1c, 0, 0, q); chk(q, 0);
    stop_test();
  end
endmodule
bind adcc_regs adcc_regs_props adcc_regs_props_i (.*);
